// ---- design/dmxdr_receiver.sv ----
// DMX512 dimming receiver: line parser, slot buffer and output stage.
// Assumes dmx_rx is already synchronous to clk and idles high.
//
// Summary of operation
// - Parse break, MAB, then 513 frames
// - First frame is start code, then channels
// - Check one start, eight data, two stops
// - 4 us bits, low start, high stops
// - Assemble data bytes least significant first
// - Nonzero start code discards whole packet
// - Slots 1 to 4 set brightness
// - Optional status slot at channel 5
// - Status 0x80 while enabled shuts down
// - Status 0x00 while shut down enables
// - Driver enable low in shutdown, else high
// - Overheat alarm high forces shutdown
`include "dmxdr_defines.svh"

// Slot buffer with valid and ready on both sides
module dmxdr_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic do_wr, do_rd;

  // Honest full and empty from the fill count
  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem[rd_ff];
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;

  // Pointer and count next values
  always_comb begin
    nxt_wr = do_wr ? wr_ff + AW'(1) : wr_ff;
    nxt_rd = do_rd ? rd_ff + AW'(1) : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  // Pointer and count registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ff] <= in_data;
    end
  end
endmodule // dmxdr_fifo

module dmxdr_receiver import dmxdr_pkg::*; #(
  parameter int BREAK_CYC = `DMXDR_BREAK_CYC,
  parameter int IDLE_CYC = `DMXDR_IDLE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // DMX serial line
  input wire logic dmx_rx,
  // Board controls
  input wire logic status_slot_en,
  input wire logic hold_updates,
  input wire logic overheat_alarm_input,
  // Dimming and driver outputs
  output logic [3:0][7:0] brightness,
  output logic driver_enable,
  // Event pulses
  output logic frame_error,
  output logic start_code_bad,
  output logic overrun
);
  localparam logic [26:0] BRK_LAST = 27'(BREAK_CYC - 1);
  localparam logic [26:0] IDLE_LAST = 27'(IDLE_CYC - 1);
  localparam logic [26:0] MAB_LAST = 27'(`DMXDR_MAB_CYC - 1);
  localparam logic [26:0] BIT_LAST = 27'(`DMXDR_BIT_CYC - 1);
  localparam logic [26:0] HALF_LAST = 27'(`DMXDR_HALF_CYC - 1);
  localparam logic [26:0] STOP_LOW = 27'(`DMXDR_STOP_LOW_CYC);
  localparam int EW = $bits(dmxdr_entry_t);

  // True for slots that the output stage consumes
  function automatic logic slot_wanted(input logic [9:0] slot,
                                       input logic st_en);
    logic [9:0] top;
    top = st_en ? {7'h00, `DMXDR_STATUS_SLOT}
                : {7'h00, `DMXDR_BRIGHT_SLOTS};
    slot_wanted = (slot != 10'h000) && (slot <= top);
  endfunction

  dmxdr_state_t state_ff, nxt_state;
  logic [26:0] cnt_ff, nxt_cnt, cnt_inc;
  logic [2:0] bitn_ff, nxt_bitn;
  logic stopn_ff, nxt_stopn;
  logic [7:0] shift_ff, nxt_shift;
  logic [9:0] slot_ff, nxt_slot;
  logic pkt_ok_ff, nxt_pkt_ok;
  logic frame_err_ff, nxt_frame_err;
  logic bad_ff, nxt_bad;
  logic overrun_ff, nxt_overrun;
  logic push, fifo_ready, pop, out_valid;
  dmxdr_entry_t in_entry, out_entry;
  logic [EW-1:0] out_raw;
  logic [3:0][7:0] bright_ff, nxt_bright;
  logic shut_ff, nxt_shut, en_ff;

  // Saturating time counter shared by every line state except idle
  assign cnt_inc = (cnt_ff == 27'h7FFFFFF) ? cnt_ff : cnt_ff + 27'h1;
  assign in_entry.slot = slot_ff[2:0];
  assign in_entry.data = shift_ff;

  // Line parser next values
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_bitn = bitn_ff;
    nxt_stopn = stopn_ff;
    nxt_shift = shift_ff;
    nxt_slot = slot_ff;
    nxt_pkt_ok = pkt_ok_ff;
    nxt_frame_err = 1'b0;
    nxt_bad = 1'b0;
    nxt_overrun = 1'b0;
    push = 1'b0;
    case (state_ff)
      DMXDR_ST_IDLE: begin
        if (!dmx_rx) begin
          nxt_state = DMXDR_ST_BREAK;
          nxt_cnt = '0;
        end
      end
      DMXDR_ST_BREAK: begin
        if (!dmx_rx) begin
          nxt_cnt = cnt_inc;
        end else if (cnt_ff >= BRK_LAST) begin
          nxt_state = DMXDR_ST_MAB;
          nxt_cnt = '0;
        end else begin
          nxt_state = DMXDR_ST_IDLE;
        end
      end
      DMXDR_ST_MAB: begin
        if (dmx_rx) begin
          nxt_cnt = cnt_inc;
          if (cnt_ff >= IDLE_LAST) begin
            nxt_state = DMXDR_ST_IDLE;
          end
        end else if (cnt_ff >= MAB_LAST) begin
          nxt_state = DMXDR_ST_START;
          nxt_cnt = '0;
          nxt_slot = '0;
          nxt_pkt_ok = 1'b1;
        end else begin
          nxt_state = DMXDR_ST_IDLE;
        end
      end
      DMXDR_ST_START: begin
        nxt_cnt = cnt_inc;
        if (cnt_ff == HALF_LAST) begin
          nxt_cnt = '0;
          // Start bit must still be low at mid-bit
          if (!dmx_rx) begin
            nxt_state = DMXDR_ST_DATA;
            nxt_bitn = '0;
          end else begin
            nxt_state = DMXDR_ST_MARK;
          end
        end
      end
      DMXDR_ST_DATA: begin
        nxt_cnt = cnt_inc;
        if (cnt_ff == BIT_LAST) begin
          nxt_cnt = '0;
          nxt_shift = {dmx_rx, shift_ff[7:1]};
          nxt_bitn = bitn_ff + 3'h1;
          if (bitn_ff == 3'h7) begin
            nxt_state = DMXDR_ST_STOP;
            nxt_stopn = 1'b0;
          end
        end
      end
      DMXDR_ST_STOP: begin
        nxt_cnt = cnt_inc;
        if (cnt_ff == BIT_LAST) begin
          nxt_cnt = '0;
          if (!dmx_rx) begin
            nxt_frame_err = 1'b1;
            nxt_pkt_ok = 1'b0;
            // A zero byte with low stop may be a break under way
            if (shift_ff == 8'h00) begin
              nxt_state = DMXDR_ST_BREAK;
              nxt_cnt = STOP_LOW;
            end else begin
              nxt_state = DMXDR_ST_IDLE;
            end
          end else if (!stopn_ff) begin
            nxt_stopn = 1'b1;
          end else begin
            nxt_state = (slot_ff == `DMXDR_LAST_SLOT) ?
                        DMXDR_ST_IDLE : DMXDR_ST_MARK;
            if (slot_ff != 10'h3FF) begin
              nxt_slot = slot_ff + 10'h001;
            end
            if (slot_ff == 10'h000) begin
              if (shift_ff != `DMXDR_START_CODE) begin
                nxt_pkt_ok = 1'b0;
                nxt_bad = 1'b1;
              end
            end else if (pkt_ok_ff &&
                         slot_wanted(slot_ff, status_slot_en)) begin
              push = fifo_ready;
              nxt_overrun = !fifo_ready;
            end
          end
        end
      end
      DMXDR_ST_MARK: begin
        if (!dmx_rx) begin
          nxt_state = DMXDR_ST_START;
          nxt_cnt = '0;
        end else begin
          nxt_cnt = cnt_inc;
          if (cnt_ff >= IDLE_LAST) begin
            nxt_state = DMXDR_ST_IDLE;
          end
        end
      end
      default: begin
        nxt_state = DMXDR_ST_IDLE;
        nxt_cnt = '0;
      end
    endcase
  end

  // Line parser registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= DMXDR_ST_IDLE;
      cnt_ff <= '0;
      bitn_ff <= '0;
      stopn_ff <= 1'b0;
      shift_ff <= '0;
      slot_ff <= '0;
      pkt_ok_ff <= 1'b0;
      frame_err_ff <= 1'b0;
      bad_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      bitn_ff <= nxt_bitn;
      stopn_ff <= nxt_stopn;
      shift_ff <= nxt_shift;
      slot_ff <= nxt_slot;
      pkt_ok_ff <= nxt_pkt_ok;
      frame_err_ff <= nxt_frame_err;
      bad_ff <= nxt_bad;
      overrun_ff <= nxt_overrun;
    end
  end

  // Slot buffer between parser and output stage
  dmxdr_fifo #(
    .WIDTH(EW),
    .DEPTH(`DMXDR_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(in_entry),
    .out_valid(out_valid),
    .out_ready(!hold_updates),
    .out_data(out_raw)
  );

  assign out_entry = dmxdr_entry_t'(out_raw);
  assign pop = out_valid & !hold_updates;

  // Brightness next values, one per channel
  generate
    for (genvar i = 0; i < 4; i++) begin : g_bright
      always_comb begin
        nxt_bright[i] = bright_ff[i];
        if (pop && out_entry.slot == 3'(i + 1)) begin
          nxt_bright[i] = out_entry.data;
        end
      end
    end
  endgenerate

  // Shutdown state next value; alarm has priority
  always_comb begin
    nxt_shut = shut_ff;
    if (overheat_alarm_input) begin
      nxt_shut = 1'b1;
    end else if (pop && status_slot_en &&
                 out_entry.slot == `DMXDR_STATUS_SLOT) begin
      if (!shut_ff && out_entry.data == `DMXDR_CMD_SHUTDOWN) begin
        nxt_shut = 1'b1;
      end else if (shut_ff && out_entry.data == `DMXDR_CMD_ENABLE) begin
        nxt_shut = 1'b0;
      end
    end
  end

  // Output stage registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bright_ff <= {4{`DMXDR_BRIGHT_RST}};
      shut_ff <= `DMXDR_SHUT_RST;
      en_ff <= !`DMXDR_SHUT_RST;
    end else begin
      bright_ff <= nxt_bright;
      shut_ff <= nxt_shut;
      en_ff <= !nxt_shut;
    end
  end

  // Outputs straight from flip-flops
  assign brightness = bright_ff;
  assign driver_enable = en_ff;
  assign frame_error = frame_err_ff;
  assign start_code_bad = bad_ff;
  assign overrun = overrun_ff;
endmodule // dmxdr_receiver

// ---- pkg/dmxdr_defines.svh ----
// Offsets-free constants for the DMX dimming receiver: timing and codes.
// Assumes a single 125 MHz system clock.
`ifndef DMXDR_DEFINES_SVH
`define DMXDR_DEFINES_SVH
// Clock rate
`define DMXDR_CLK_KHZ 125000
// Line timing in its own units
`define DMXDR_BIT_US 4
`define DMXDR_BREAK_MIN_US 88
`define DMXDR_MAB_MIN_US 8
`define DMXDR_IDLE_MAX_MS 1000
// Cycle counts; least times round up, longest times round down
`define DMXDR_BIT_CYC (`DMXDR_BIT_US * `DMXDR_CLK_KHZ / 1000)
`define DMXDR_HALF_CYC (`DMXDR_BIT_CYC / 2)
`define DMXDR_BREAK_CYC \
  ((`DMXDR_BREAK_MIN_US * `DMXDR_CLK_KHZ + 999) / 1000)
`define DMXDR_MAB_CYC ((`DMXDR_MAB_MIN_US * `DMXDR_CLK_KHZ + 999) / 1000)
`define DMXDR_IDLE_CYC (`DMXDR_IDLE_MAX_MS * `DMXDR_CLK_KHZ)
// Low time already spent when a zero byte shows a low stop bit
`define DMXDR_STOP_LOW_CYC (19 * `DMXDR_HALF_CYC)
// Packet layout
`define DMXDR_START_CODE 8'h00
`define DMXDR_LAST_SLOT 10'h200
`define DMXDR_BRIGHT_SLOTS 3'h4
`define DMXDR_STATUS_SLOT 3'h5
// Status command values
`define DMXDR_CMD_SHUTDOWN 8'h80
`define DMXDR_CMD_ENABLE 8'h00
// Reset values
`define DMXDR_BRIGHT_RST 8'h00
`define DMXDR_SHUT_RST 1'b0
// Buffer shape
`define DMXDR_FIFO_DEPTH 32
`endif

// ---- pkg/dmxdr_pkg.sv ----
// Types shared by the DMX dimming receiver.
// Assumes the defines header is compiled alongside.
package dmxdr_pkg;
  // Line parser states, one-hot
  typedef enum logic [6:0] {
    DMXDR_ST_IDLE  = 7'h01,
    DMXDR_ST_BREAK = 7'h02,
    DMXDR_ST_MAB   = 7'h04,
    DMXDR_ST_START = 7'h08,
    DMXDR_ST_DATA  = 7'h10,
    DMXDR_ST_STOP  = 7'h20,
    DMXDR_ST_MARK  = 7'h40
  } dmxdr_state_t;
  // One buffered slot: its number and its data byte
  typedef struct packed {
    logic [2:0] slot;
    logic [7:0] data;
  } dmxdr_entry_t;
endpackage

// ---- tb/dmxdr_receiver_monitor.sv ----
// Port checker for the dimming receiver, bound to each instance.
// Assumes one clock domain and the hand-over timing of the outputs.
module dmxdr_receiver_monitor import dmxdr_pkg::*; #(
  parameter int BREAK_CYC = 11000,
  parameter int IDLE_CYC = 125000000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Design inputs
  input wire logic dmx_rx,
  input wire logic status_slot_en,
  input wire logic hold_updates,
  input wire logic overheat_alarm_input,
  // Design outputs
  input wire logic [3:0][7:0] brightness,
  input wire logic driver_enable,
  input wire logic frame_error,
  input wire logic start_code_bad,
  input wire logic overrun
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Values held during and just after reset
  AST_RST_VAL: assert property (disable iff (1'b0)
    rst |=> driver_enable && brightness == '0)
    else $error("reset values wrong");
  // Driver enable against alarm and commands
  AST_ALARM_SHUT: assert property (
    overheat_alarm_input [*2] |=> !driver_enable)
    else $error("alarm did not shut the driver down");
  AST_ALARM_WINS: assert property (
    $rose(driver_enable) |->
      !$past(overheat_alarm_input) && $past(status_slot_en))
    else $error("enable during alarm or without status slot");
  AST_SHUT_CAUSE: assert property (
    $fell(driver_enable) |-> $past(overheat_alarm_input) ||
      $past(overheat_alarm_input, 2) || $past(status_slot_en))
    else $error("shutdown without a cause");
  // Event pulses last one cycle and follow the line
  AST_FE_PULSE: assert property (
    frame_error |-> !$past(dmx_rx) ##1 !frame_error)
    else $error("frame error pulse wrong");
  AST_SCB_PULSE: assert property (
    start_code_bad |-> $past(dmx_rx) ##1 !start_code_bad)
    else $error("start code pulse wrong");
  // Held updates freeze brightness and are the only cause of overrun
  AST_HOLD_FREEZE: assert property (
    hold_updates [*3] |=> $stable(brightness))
    else $error("brightness moved while held");
  AST_OVERRUN_HELD: assert property (
    overrun |-> hold_updates ##1 !overrun)
    else $error("overrun pulse wrong");
  // Main scenarios
  cover property ($fell(driver_enable) && status_slot_en);
  cover property (frame_error);
  cover property (start_code_bad);
  cover property ($fell(hold_updates) ##[1:8] $rose(driver_enable));
endmodule // dmxdr_receiver_monitor

bind dmxdr_receiver dmxdr_receiver_monitor #(
  .BREAK_CYC(BREAK_CYC), .IDLE_CYC(IDLE_CYC)
) u_mon (
  .clk(clk), .rst(rst), .dmx_rx(dmx_rx), .status_slot_en(status_slot_en),
  .hold_updates(hold_updates), .overheat_alarm_input(overheat_alarm_input),
  .brightness(brightness), .driver_enable(driver_enable),
  .frame_error(frame_error), .start_code_bad(start_code_bad),
  .overrun(overrun)
);

// ---- tb/dmxdr_ctrl_model.sv ----
// Lighting controller line model: breaks, marks and serial frames.
// Assumes its tasks are called at a falling clock edge, one at a time.
module dmxdr_ctrl_model #(
  parameter int BIT_CYC = 500,
  parameter int MAB_CYC = 1010
) (
  // Clock
  input wire logic clk,
  // Serial line towards the receiver
  output logic tx
);
  timeunit 1ns;
  timeprecision 1ps;
  // Line idles at mark
  initial tx = 1'b1;
  // Hold one level for a number of cycles
  task automatic hold_level(input logic lvl, input int cycles);
    tx = lvl;
    repeat (cycles) @(negedge clk);
  endtask
  // Break then mark after break
  task automatic send_break(input int low);
    hold_level(1'b0, low);
    hold_level(1'b1, MAB_CYC);
  endtask
  // One frame: start, eight bits from the bottom, two stops
  task automatic send_byte(input logic [7:0] d, input logic stop_ok);
    hold_level(1'b0, BIT_CYC);
    for (int i = 0; i < 8; i++) hold_level(d[i], BIT_CYC);
    hold_level(stop_ok, BIT_CYC);
    hold_level(1'b1, BIT_CYC);
  endtask
endmodule // dmxdr_ctrl_model

// ---- tb/tb_dmx_dimming_receiver.sv ----
// Self-checking bench for the dimming receiver and its line model.
// Assumes checker and model compile first; short break parameter.
module tb_dmx_dimming_receiver;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(what, exp, got) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("Error %s expected %0h seen %0h", what, exp, got); \
    end \
  end
  // Stimulus and observed outputs
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic dmx_rx;
  logic status_slot_en = 1'b1;
  logic hold_updates = 1'b0;
  logic overheat_alarm_input = 1'b0;
  logic [3:0][7:0] brightness;
  logic driver_enable;
  logic frame_error;
  logic start_code_bad;
  logic overrun;
  logic [3:0][7:0] exp_b;
  logic exp_en;
  logic [7:0] pay [5];
  int n_mismatch = 0;
  int tests_run = 0;
  int n_fe = 0;
  int n_scb = 0;
  int n_ovr = 0;
  int fe0;
  int scb0;
  int cyc = 0;
  // Line model and design
  dmxdr_ctrl_model u_ctrl (.clk(clk), .tx(dmx_rx));
  dmxdr_receiver #(.BREAK_CYC(100), .IDLE_CYC(20000)) u_dut (
    .clk(clk), .rst(rst), .dmx_rx(dmx_rx), .status_slot_en(status_slot_en),
    .hold_updates(hold_updates), .overheat_alarm_input(overheat_alarm_input),
    .brightness(brightness), .driver_enable(driver_enable),
    .frame_error(frame_error), .start_code_bad(start_code_bad),
    .overrun(overrun)
  );
  // Clock at 125 MHz
  initial forever #4 clk = ~clk;
  // Pulse counts and hang guard, sampled away from the launching edge
  always @(negedge clk) begin
    cyc++;
    if (frame_error === 1'b1) n_fe++;
    if (start_code_bad === 1'b1) n_scb++;
    if (overrun === 1'b1) n_ovr++;
    if (cyc == 110000) begin
      n_mismatch++;
      test_done();
    end
  end
  // Next enable state from a status byte
  function automatic logic next_en(input logic cur, input logic [7:0] cmd);
    if (cmd == 8'h80) return 1'b0;
    if (cmd == 8'h00) return 1'b1;
    return cur;
  endfunction
  // One packet: break, start code, then n slots
  task automatic send_pkt(input logic [7:0] sc, input int n, input logic ok,
                          input int brk);
    u_ctrl.send_break(brk);
    fe0 = n_fe;
    scb0 = n_scb;
    u_ctrl.send_byte(sc, ok);
    for (int i = 0; i < n; i++) u_ctrl.send_byte(pay[i], 1'b1);
    repeat (10) @(negedge clk);
  endtask
  // Counts, verdict and end of run
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(76803));
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    exp_b = '0;
    exp_en = 1'b1;
    `CHK("reset brightness", exp_b, brightness)
    `CHK("reset driver_enable", exp_en, driver_enable)
    // Brightness with a low bit marker, then shutdown command
    pay[0] = 8'h01;
    for (int i = 1; i < 4; i++) pay[i] = 8'($urandom);
    pay[4] = 8'h80;
    send_pkt(8'h00, 5, 1'b1, 200);
    for (int i = 0; i < 4; i++) exp_b[i] = pay[i];
    exp_en = next_en(exp_en, pay[4]);
    `CHK("brightness", exp_b, brightness)
    `CHK("driver_enable", exp_en, driver_enable)
    // Nonzero start code leaves the outputs alone
    pay[0] = ~exp_b[0];
    send_pkt(8'($urandom % 255 + 1), 1, 1'b1, 4800);
    `CHK("start_code_bad", scb0 + 1, n_scb)
    `CHK("brightness", exp_b, brightness)
    // Held updates, then enable command on release
    hold_updates = 1'b1;
    for (int i = 0; i < 4; i++) pay[i] = 8'($urandom);
    pay[4] = 8'h00;
    send_pkt(8'h00, 5, 1'b1, 4800);
    `CHK("held brightness", exp_b, brightness)
    hold_updates = 1'b0;
    repeat (10) @(negedge clk);
    for (int i = 0; i < 4; i++) exp_b[i] = pay[i];
    exp_en = next_en(exp_en, pay[4]);
    `CHK("brightness", exp_b, brightness)
    `CHK("driver_enable", exp_en, driver_enable)
    // Overheat alarm forces shutdown and it stays after the alarm
    overheat_alarm_input = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("driver_enable", 1'b0, driver_enable)
    overheat_alarm_input = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("driver_enable", 1'b0, driver_enable)
    // Low stop bit in the start code frame
    send_pkt(8'hA5, 0, 1'b0, 4800);
    `CHK("frame_error", fe0 + 1, n_fe)
    `CHK("brightness", exp_b, brightness)
    // No wanted slot was ever dropped in these scenarios
    `CHK("overrun", 0, n_ovr)
    test_done();
  end
endmodule // tb_dmx_dimming_receiver
